// ===== dscg_gate_ctrl.sv
// deep-sleep unit clock gate register and its run and sleep companions
// Notes on behaviour
// RULE_01: each implemented bit drives one unit clock enable, set is clocked.
// RULE_02: access to a unit whose clock is gated off returns a bus fault.
// RULE_03: all gate bits are zero after reset, so units start unclocked.
// RULE_04: software enables each unit's gate bit before touching that unit.
// RULE_05: three gate registers exist: run, sleep and deep-sleep.
// RULE_06: sleep and deep-sleep registers apply only with auto gating set.
// RULE_07: deep-sleep gate register sits at offset 0x124 of system control.
// RULE_08: bit 25 gates comparator one, bit 24 comparator zero, read-write.
// RULE_09: bits 18, 17, 16 gate counters two, one, zero, read-write.
// RULE_10: bit 4 gates sync serial zero, read-write.
// RULE_11: bit 0 gates async serial zero, read-write.
// RULE_12: reserved bits are read-only and read as zero.
// RULE_13: deep-sleep with auto gating selects this register, sleep with auto gating the sleep one, else run one.
//
// The implementer's own choice: strobed register access.
`default_nettype none
module dscg_gate_ctrl
  import dscg_pkg::*;
#(
  parameter int NUNIT = DSCG_NUNIT
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // register port
  input  wire logic [DSCG_AW-1:0]  reg_addr,
  input  wire logic [DSCG_DW-1:0]  reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DSCG_DW-1:0]  reg_rdata,
  // power state from the power manager
  input  wire logic                sleep_req,
  input  wire logic                deep_req,
  // unit bus access strobes
  input  wire logic [NUNIT-1:0]    unit_access,
  output logic                     unit_fault,
  // unit clock enables
  output logic      [NUNIT-1:0]    unit_clk_en,
  // interrupt
  output logic                     irq
);
  import dscg_pkg::*;

  // ===========================================================
  // helpers
  function automatic logic [NUNIT-1:0] pack_gates(input logic [31:0] w);
    pack_gates = {w[DSCG_COMPARATOR_ONE_GATE_BIT], w[DSCG_COMPARATOR_ZERO_GATE_BIT], // RULE_08
                  w[DSCG_GPT2_BIT], w[DSCG_GPT1_BIT],
                  w[DSCG_GPT0_BIT], // RULE_09
                  w[DSCG_SSI_BIT], // RULE_10
                  w[DSCG_ASY_BIT]}; // RULE_11
  endfunction : pack_gates

  function automatic logic hit(input logic [DSCG_AW-1:0] a,
                               input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ===========================================================
  // registers
  logic [31:0]          run_unit_clock_gate_one_r;
  logic [31:0]          sleep_unit_clock_gate_one_r;
  logic [31:0]          deep_sleep_unit_clock_gate_one_r;
  logic                 auto_gating_select_r;
  logic [DSCG_NIRQ-1:0] irq_stat_r;
  logic [DSCG_NIRQ-1:0] irq_en_r;
  logic [NUNIT-1:0]     fault_unit_r;
  dscg_pwr_type         pwr_r;
  dscg_pwr_type         pwr_nxt;
  logic [NUNIT-1:0]     gate_sel;
  logic                 fault_now;
  logic [DSCG_NIRQ-1:0] irq_set;
  logic [DSCG_NIRQ-1:0] irq_clr;

  // ===========================================================
  // gate registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_unit_clock_gate_one_r <= DSCG_GATE_RST; // RULE_03
    end else if (reg_wr && hit(reg_addr, DSCG_RUN_OFS)) begin // RULE_05
      run_unit_clock_gate_one_r <= reg_wdata & DSCG_GATE_MASK; // RULE_12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_unit_clock_gate_one_r <= DSCG_GATE_RST; // RULE_03
    end else if (reg_wr && hit(reg_addr, DSCG_SLP_OFS)) begin // RULE_05
      sleep_unit_clock_gate_one_r <= reg_wdata & DSCG_GATE_MASK; // RULE_12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_unit_clock_gate_one_r <= DSCG_GATE_RST; // RULE_03
    end else if (reg_wr && hit(reg_addr, DSCG_DSL_OFS)) begin // RULE_07
      // reserved bits are dropped on write
      deep_sleep_unit_clock_gate_one_r <=
        reg_wdata & DSCG_GATE_MASK; // RULE_12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_gating_select_r <= 1'b0;
    end else if (reg_wr && hit(reg_addr, DSCG_CFG_OFS)) begin
      auto_gating_select_r <= reg_wdata[DSCG_CFG_AUTO_BIT];
    end
  end

  // ===========================================================
  // power state machine
  always_comb begin
    pwr_nxt = DSCG_RUN;
    if (deep_req) begin
      pwr_nxt = DSCG_DEEP;
    end else if (sleep_req) begin
      pwr_nxt = DSCG_SLEEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_r <= DSCG_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // ===========================================================
  // gate select and fault check
  dscg_unit_sel #(
    .NUNIT              (NUNIT)
  ) u_sel (
    .pwr_state          (pwr_r),
    .auto_gating_select (auto_gating_select_r), // RULE_06
    .run_gate           (pack_gates(run_unit_clock_gate_one_r)),
    .sleep_gate         (pack_gates(sleep_unit_clock_gate_one_r)),
    .deep_gate          (pack_gates(deep_sleep_unit_clock_gate_one_r)),
    .unit_access        (unit_access),
    .gate_sel           (gate_sel),
    .fault              (fault_now)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_clk_en <= '0;
    end else begin
      unit_clk_en <= gate_sel; // RULE_01
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_fault   <= 1'b0;
      fault_unit_r <= '0;
    end else begin
      unit_fault <= fault_now; // RULE_02
      if (fault_now) begin
        fault_unit_r <= unit_access & ~gate_sel;
      end
    end
  end

  // ===========================================================
  // interrupts: fault event and wake from deep-sleep
  assign irq_set[DSCG_IRQ_FAULT_BIT] = fault_now;
  assign irq_set[DSCG_IRQ_WAKE_BIT]  = (pwr_r == DSCG_DEEP) &&
                                       (pwr_nxt != DSCG_DEEP);
  assign irq_clr = (reg_wr && hit(reg_addr, DSCG_ICLR_OFS)) ?
                   reg_wdata[DSCG_NIRQ-1:0] : '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= DSCG_IRQ_RST;
    end else begin
      // set wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en_r <= DSCG_IRQ_RST;
    end else if (reg_wr && hit(reg_addr, DSCG_IEN_OFS)) begin
      irq_en_r <= reg_wdata[DSCG_NIRQ-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_en_r);
    end
  end

  // ===========================================================
  // read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        DSCG_RUN_OFS:   reg_rdata <= run_unit_clock_gate_one_r;
        DSCG_SLP_OFS:   reg_rdata <= sleep_unit_clock_gate_one_r;
        DSCG_DSL_OFS: begin // RULE_12
          reg_rdata <= deep_sleep_unit_clock_gate_one_r;
        end
        DSCG_CFG_OFS:   reg_rdata <= {31'h0, auto_gating_select_r};
        DSCG_IST_OFS:   reg_rdata <= {30'h0, irq_stat_r};
        DSCG_IEN_OFS:   reg_rdata <= {30'h0, irq_en_r};
        DSCG_FADDR_OFS: reg_rdata <= {25'h0, fault_unit_r};
        default:        reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ===========================================================
  // checks
  gate_reset_a: assert property (@(posedge ref_clk) // RULE_03
    $rose(rst_n) |-> deep_sleep_unit_clock_gate_one_r == 32'h0)
    else $error("gate register not clear after reset");

  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (deep_sleep_unit_clock_gate_one_r & ~DSCG_GATE_MASK) == 32'h0) // RULE_12
    else $error("reserved gate bit set");

  deep_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    reg_wr && reg_addr == 12'h124 |=> // RULE_07
    deep_sleep_unit_clock_gate_one_r == ($past(reg_wdata) & 32'h0307_0011))
    else $error("deep gate write not stored");

  deep_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auto_gating_select_r && pwr_r == DSCG_DEEP |=> // RULE_13
    unit_clk_en == $past(pack_gates(deep_sleep_unit_clock_gate_one_r)))
    else $error("deep-sleep gate not applied");

  run_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !auto_gating_select_r |=> // RULE_06
    unit_clk_en == $past(pack_gates(run_unit_clock_gate_one_r)))
    else $error("run gate not applied without auto gating");

  comp_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auto_gating_select_r && pwr_r == DSCG_DEEP |=> // RULE_08
    unit_clk_en[6:5] == $past(deep_sleep_unit_clock_gate_one_r[25:24]))
    else $error("comparator gates misplaced");

  counter_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auto_gating_select_r && pwr_r == DSCG_DEEP |=> // RULE_09
    unit_clk_en[4:2] == $past(deep_sleep_unit_clock_gate_one_r[18:16]))
    else $error("counter gates misplaced");

  serial_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    auto_gating_select_r && pwr_r == DSCG_DEEP |=> // RULE_10
    unit_clk_en[1:0] == {$past(deep_sleep_unit_clock_gate_one_r[4]),
                         $past(deep_sleep_unit_clock_gate_one_r[0])}) // RULE_11
    else $error("serial gates misplaced");

  unit_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    |(unit_access & ~gate_sel) |=> unit_fault) // RULE_02
    else $error("access to gated unit not faulted");

  fault_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    unit_fault |-> irq_stat_r[DSCG_IRQ_FAULT_BIT]) // RULE_02
    else $error("fault event not recorded");

  // ===========================================================
  // checks: read port, interrupts, power state
  rdata_idle_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  rdata_reserved_a: assert property (@(posedge ref_clk) // RULE_12
    disable iff (!rst_n) reg_rd && reg_addr == DSCG_DSL_OFS |=>
    (reg_rdata & ~DSCG_GATE_MASK) == 32'h0000_0000)
    else $error("reserved gate bit read as one");

  reserved_other_a: assert property (@(posedge ref_clk) // RULE_12
    disable iff (!rst_n) ((run_unit_clock_gate_one_r |
    sleep_unit_clock_gate_one_r) & ~DSCG_GATE_MASK) == 32'h0000_0000)
    else $error("reserved bit set in run or sleep gates");

  sleep_select_a: assert property (@(posedge ref_clk) // RULE_06
    disable iff (!rst_n) auto_gating_select_r && pwr_r == DSCG_SLEEP |=>
    unit_clk_en == $past(pack_gates(sleep_unit_clock_gate_one_r)))
    else $error("sleep gate not applied");

  auto_run_a: assert property (@(posedge ref_clk) // RULE_13
    disable iff (!rst_n) auto_gating_select_r && pwr_r == DSCG_RUN |=>
    unit_clk_en == $past(pack_gates(run_unit_clock_gate_one_r)))
    else $error("run gate not applied while running");

  gate_hold_a: assert property (@(posedge ref_clk) // RULE_07
    disable iff (!rst_n) !(reg_wr && reg_addr == DSCG_DSL_OFS) |=>
    $stable(deep_sleep_unit_clock_gate_one_r))
    else $error("deep gate changed without a write");

  no_fault_a: assert property (@(posedge ref_clk) // RULE_02
    disable iff (!rst_n) !(|(unit_access & ~gate_sel)) |=> !unit_fault)
    else $error("fault raised for a clocked unit");

  fault_unit_a: assert property (@(posedge ref_clk) // RULE_02
    disable iff (!rst_n) unit_fault |-> fault_unit_r != '0)
    else $error("faulting unit not captured");

  reset_outputs_a: assert property (@(posedge ref_clk) // RULE_03
    $rose(rst_n) |-> unit_clk_en == '0 && !unit_fault && !irq)
    else $error("outputs not clear after reset");

  irq_level_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) irq == |(irq_stat_r & $past(irq_en_r)))
    else $error("interrupt level does not follow status");

  wake_event_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) pwr_r == DSCG_DEEP && !deep_req |=>
    irq_stat_r[DSCG_IRQ_WAKE_BIT])
    else $error("wake from deep-sleep not recorded");

  fault_clear_a: assert property (@(posedge ref_clk)
    disable iff (!rst_n) reg_wr && reg_addr == DSCG_ICLR_OFS &&
    reg_wdata[DSCG_IRQ_FAULT_BIT] && !fault_now |=>
    !irq_stat_r[DSCG_IRQ_FAULT_BIT])
    else $error("fault status not cleared");

  set_wins_a: assert property (@(posedge ref_clk) // RULE_02
    disable iff (!rst_n) fault_now |=> irq_stat_r[DSCG_IRQ_FAULT_BIT])
    else $error("fault event lost to a clear");

  deep_follow_a: assert property (@(posedge ref_clk) // RULE_05
    disable iff (!rst_n) deep_req |=> pwr_r == DSCG_DEEP)
    else $error("deep-sleep request not taken");

  sleep_follow_a: assert property (@(posedge ref_clk) // RULE_05
    disable iff (!rst_n) sleep_req && !deep_req |=> pwr_r == DSCG_SLEEP)
    else $error("sleep request not taken");

  cfg_write_a: assert property (@(posedge ref_clk) // RULE_06
    disable iff (!rst_n) reg_wr && reg_addr == DSCG_CFG_OFS |=>
    auto_gating_select_r == $past(reg_wdata[DSCG_CFG_AUTO_BIT]))
    else $error("auto gating select not stored");
endmodule : dscg_gate_ctrl
`default_nettype wire

// ===== dscg_gate_ctrl_tb_top.sv
// self-checking bench for the unit clock gating block
`default_nettype none
module dscg_gate_ctrl_tb_top;
  import dscg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================================================
  // stimulus and observation
  logic                ref_clk;
  logic                rst_n;
  logic [DSCG_AW-1:0]  reg_addr;
  logic [DSCG_DW-1:0]  reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [DSCG_DW-1:0]  reg_rdata;
  logic                sleep_req;
  logic                deep_req;
  logic [6:0]          unit_access;
  logic                unit_fault;
  logic [6:0]          unit_clk_en;
  logic                irq;
  logic [31:0]         exp_q[$];
  logic                rd_seen;
  int                  n_fail;
  int                  compares;
  int                  cyc;
  logic [31:0]         r_val;
  logic [31:0]         s_val;
  logic [31:0]         d_val;
  logic [31:0]         w_val;
  // ===========================================================
  // design
  dscg_gate_ctrl #(.NUNIT(7)) dscg_gate_ctrl_i (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .sleep_req   (sleep_req),
    .deep_req    (deep_req),
    .unit_access (unit_access),
    .unit_fault  (unit_fault),
    .unit_clk_en (unit_clk_en),
    .irq         (irq)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ===========================================================
  // checking and closing
  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  function automatic logic [6:0] unit_bits(input logic [31:0] v);
    return {v[25], v[24], v[18], v[17], v[16], v[4], v[0]};
  endfunction : unit_bits
  // read data stands in the cycle after the strobe only
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0)
      check("reg_rdata", exp_q.pop_front(), reg_rdata);
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ===========================================================
  // bus and unit tasks
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
  endtask : rd
  task automatic acc(input logic [6:0] u, input logic f);
    @(posedge ref_clk);
    unit_access <= u;
    @(posedge ref_clk);
    unit_access <= 7'h00;
    #1 check("unit_fault", {31'h0, f}, {31'h0, unit_fault});
  endtask : acc
  task automatic set_pwr(input logic au, input logic sl, input logic dp,
                         input logic [31:0] src);
    wr(DSCG_CFG_OFS, {31'h0, au});
    @(posedge ref_clk);
    sleep_req <= sl;
    deep_req  <= dp;
    repeat (3) @(posedge ref_clk);
    #1 check("unit_clk_en", {25'h0, unit_bits(src)},
             {25'h0, unit_clk_en});
  endtask : set_pwr
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    #1 check("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is
  // ===========================================================
  // main sequence
  initial begin
    void'($urandom(30336));
    rst_n = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_req = 1'b0;
    deep_req = 1'b0;
    unit_access = 7'h00;
    rd_seen = 1'b0;
    n_fail = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(DSCG_DSL_OFS, DSCG_GATE_RST);
    rd(DSCG_RUN_OFS, DSCG_GATE_RST);
    rd(DSCG_SLP_OFS, DSCG_GATE_RST);
    check("unit_clk_en", 32'h0, {25'h0, unit_clk_en});
    // faults on gated units, interrupt raised, captured and cleared
    wr(DSCG_IEN_OFS, 32'h0000_0001);
    acc(7'h01, 1'b1);
    irq_is(1'b1);
    rd(DSCG_IST_OFS, 32'h0000_0001);
    rd(DSCG_FADDR_OFS, 32'h0000_0001);
    wr(DSCG_ICLR_OFS, 32'h0000_0001);
    irq_is(1'b0);
    wr(DSCG_RUN_OFS, 32'h0000_0001);
    acc(7'h01, 1'b0);
    wr(DSCG_IEN_OFS, 32'h0000_0000);
    acc(7'h40, 1'b1);
    irq_is(1'b0);
    rd(DSCG_IST_OFS, 32'h0000_0001);
    wr(DSCG_ICLR_OFS, 32'h0000_0001);
    rd(DSCG_IST_OFS, 32'h0000_0000);
    // field layout, reserved bits, unmapped place
    wr(DSCG_DSL_OFS, 32'hFFFF_FFFF);
    rd(DSCG_DSL_OFS, DSCG_GATE_MASK);
    for (int i = 0; i < 6; i++) begin
      w_val = $urandom;
      wr(DSCG_DSL_OFS, w_val);
      rd(DSCG_DSL_OFS, w_val & DSCG_GATE_MASK);
    end
    rd(12'h300, 32'h0000_0000);
    // gate source selection per power state
    r_val = $urandom & DSCG_GATE_MASK;
    s_val = $urandom & DSCG_GATE_MASK;
    d_val = $urandom & DSCG_GATE_MASK;
    wr(DSCG_RUN_OFS, r_val);
    wr(DSCG_SLP_OFS, s_val);
    wr(DSCG_DSL_OFS, d_val);
    set_pwr(1'b0, 1'b0, 1'b0, r_val);
    set_pwr(1'b0, 1'b0, 1'b1, r_val);
    set_pwr(1'b1, 1'b0, 1'b1, d_val);
    set_pwr(1'b1, 1'b1, 1'b0, s_val);
    set_pwr(1'b1, 1'b1, 1'b1, d_val);
    set_pwr(1'b1, 1'b0, 1'b0, r_val);
    rd(DSCG_IST_OFS, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    give_verdict();
  end
endmodule : dscg_gate_ctrl_tb_top
`default_nettype wire

// ===== dscg_pkg.sv
// package: register map and field layout for the unit clock gating block
`default_nettype none
package dscg_pkg;
  // ===========================================================
  // geometry
  localparam int          DSCG_AW         = 12;
  localparam int          DSCG_DW         = 32;
  localparam int          DSCG_NUNIT      = 7;
  localparam logic [31:0] DSCG_SYS_BASE   = 32'h400F_E000;
  // ===========================================================
  // register offsets
  localparam logic [11:0] DSCG_RUN_OFS    = 12'h104;
  localparam logic [11:0] DSCG_SLP_OFS    = 12'h114;
  localparam logic [11:0] DSCG_DSL_OFS    = 12'h124;
  localparam logic [11:0] DSCG_CFG_OFS    = 12'h200;
  localparam logic [11:0] DSCG_IST_OFS    = 12'h204;
  localparam logic [11:0] DSCG_IEN_OFS    = 12'h208;
  localparam logic [11:0] DSCG_ICLR_OFS   = 12'h20C;
  localparam logic [11:0] DSCG_FADDR_OFS  = 12'h210;
  // ===========================================================
  // field positions of the gate registers
  localparam int DSCG_COMPARATOR_ONE_GATE_BIT = 25;
  localparam int DSCG_COMPARATOR_ZERO_GATE_BIT = 24;
  localparam int DSCG_GPT2_BIT  = 18;
  localparam int DSCG_GPT1_BIT  = 17;
  localparam int DSCG_GPT0_BIT  = 16;
  localparam int DSCG_SSI_BIT   = 4;
  localparam int DSCG_ASY_BIT   = 0;
  localparam logic [31:0] DSCG_GATE_MASK  = 32'h0307_0011;
  localparam logic [31:0] DSCG_GATE_RST   = 32'h0000_0000;
  // ===========================================================
  // config and interrupt fields
  localparam int DSCG_CFG_AUTO_BIT  = 0;
  localparam int DSCG_IRQ_FAULT_BIT = 0;
  localparam int DSCG_IRQ_WAKE_BIT  = 1;
  localparam int DSCG_NIRQ          = 2;
  localparam logic [1:0] DSCG_IRQ_RST = 2'h0;
  // ===========================================================
  // power states
  typedef enum logic [2:0] {
    DSCG_RUN   = 3'b001,
    DSCG_SLEEP = 3'b010,
    DSCG_DEEP  = 3'b100
  } dscg_pwr_type;
endpackage : dscg_pkg
`default_nettype wire

// ===== dscg_unit_sel.sv
// per-unit gate select and unit bus fault check
`default_nettype none
module dscg_unit_sel
  import dscg_pkg::*;
#(
  parameter int NUNIT = 7
) (
  // state
  input  wire dscg_pwr_type     pwr_state,
  input  wire logic             auto_gating_select,
  // gate sources
  input  wire logic [NUNIT-1:0] run_gate,
  input  wire logic [NUNIT-1:0] sleep_gate,
  input  wire logic [NUNIT-1:0] deep_gate,
  // unit access
  input  wire logic [NUNIT-1:0] unit_access,
  // results
  output logic      [NUNIT-1:0] gate_sel,
  output logic                  fault
);
  always_comb begin
    gate_sel = run_gate;
    if (auto_gating_select && pwr_state == DSCG_SLEEP) begin
      gate_sel = sleep_gate;
    end else if (auto_gating_select && pwr_state == DSCG_DEEP) begin
      gate_sel = deep_gate; // RULE_13
    end
  end

  assign fault = |(unit_access & ~gate_sel); // RULE_02
endmodule : dscg_unit_sel
`default_nettype wire
